// [hdl/tag_pkg.sv]
// package: constants and types for the test access port block
package tag_pkg;

  // ==========================================
  // instruction register
  localparam int          IR_W          = 2;
  localparam logic [1:0]  IR_EXTEST     = 2'h0;
  localparam logic [1:0]  IR_IDCODE     = 2'h1;
  localparam logic [1:0]  IR_BYPASS     = 2'h3;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  localparam logic [1:0]  IR_RESET_VAL  = IR_IDCODE;

  // ==========================================
  // identification register, value arbitrary
  localparam int          ID_W          = 32;
  localparam logic [31:0] ID_VALUE      = 32'h1234_5001;

  // ==========================================
  // data register of the boundary path
  localparam int          BSR_W         = 8;

  // ==========================================
  // reset values of pin samplers
  localparam logic [1:0]  SYNC_RST_HI   = 2'h3;
  localparam logic [1:0]  SYNC_RST_LO   = 2'h0;

  // ==========================================
  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SELDR  = 16'h0004,
    ST_CAPDR  = 16'h0008,
    ST_SHDR   = 16'h0010,
    ST_EX1DR  = 16'h0020,
    ST_PAUDR  = 16'h0040,
    ST_EX2DR  = 16'h0080,
    ST_UPDDR  = 16'h0100,
    ST_SELIR  = 16'h0200,
    ST_CAPIR  = 16'h0400,
    ST_SHIR   = 16'h0800,
    ST_EX1IR  = 16'h1000,
    ST_PAUIR  = 16'h2000,
    ST_EX2IR  = 16'h4000,
    ST_UPDIR  = 16'h8000
  } tag_state_t;

  // test pins grouped
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tag_pins_t;

endpackage : tag_pkg

// [hdl/tag_test_port.sv]
// module: test access port controller with global reset and pin tri-state control
`timescale 1ns/1ps

module tag_test_port
  import tag_pkg::*;
(
  // system
  input  wire logic clk,
  input  wire logic srst,
  // device pins
  input  wire logic chip_reset_n,
  input  wire logic digital_io_enable_pin,
  input  wire logic test_port_reset_n,
  input  wire logic test_clock_pin,
  input  wire logic test_mode_select_pin,
  input  wire logic test_serial_in_pin,
  // serial output, three-state
  output logic      test_serial_out_pin,
  output logic      test_serial_out_oe,
  // device-wide controls
  output logic      core_reset,
  output logic      test_mode_active,
  output logic      io_pins_hiz
);

  // ==========================================
  // pin synchronisers
  logic [1:0] rst_sy_q;
  logic [1:0] ck_sy_q;
  logic [1:0] ms_sy_q;
  logic [1:0] di_sy_q;
  logic [1:0] ioe_sy_q;
  logic [1:0] crst_sy_q;
  logic       ck_prev_q;
  tag_pins_t  pins;

  // two flops per pin, pins sampled on clk
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rst_sy_q  <= SYNC_RST_LO;
      ck_sy_q   <= SYNC_RST_LO;
      ms_sy_q   <= SYNC_RST_HI;
      di_sy_q   <= SYNC_RST_HI;
      ioe_sy_q  <= SYNC_RST_HI;
      crst_sy_q <= SYNC_RST_LO;
      ck_prev_q <= 1'b0;
    end
    else
    begin
      rst_sy_q  <= {rst_sy_q[0], test_port_reset_n};
      ck_sy_q   <= {ck_sy_q[0], test_clock_pin};
      ms_sy_q   <= {ms_sy_q[0], test_mode_select_pin};
      di_sy_q   <= {di_sy_q[0], test_serial_in_pin};
      ioe_sy_q  <= {ioe_sy_q[0], digital_io_enable_pin};
      crst_sy_q <= {crst_sy_q[0], chip_reset_n};
      ck_prev_q <= ck_sy_q[1];
    end
  end

  assign pins.tck = ck_sy_q[1];
  assign pins.tms = ms_sy_q[1];
  assign pins.tdi = di_sy_q[1];

  logic tck_rise;
  logic tck_fall;
  logic trst_act;
  assign tck_rise = pins.tck & ~ck_prev_q;
  assign tck_fall = ~pins.tck & ck_prev_q;
  // test reset acts level-sensitive, no test clock edge
  assign trst_act = ~rst_sy_q[1] | srst;

  // ==========================================
  // controller state machine
  tag_state_t st_q;
  tag_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_RESET: st_d = pins.tms ? ST_RESET : ST_IDLE;
      ST_IDLE:  st_d = pins.tms ? ST_SELDR : ST_IDLE;
      ST_SELDR: st_d = pins.tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: st_d = pins.tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  st_d = pins.tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: st_d = pins.tms ? ST_UPDDR : ST_PAUDR;
      ST_PAUDR: st_d = pins.tms ? ST_EX2DR : ST_PAUDR;
      ST_EX2DR: st_d = pins.tms ? ST_UPDDR : ST_SHDR;
      ST_UPDDR: st_d = pins.tms ? ST_SELDR : ST_IDLE;
      ST_SELIR: st_d = pins.tms ? ST_RESET : ST_CAPIR;
      ST_CAPIR: st_d = pins.tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  st_d = pins.tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: st_d = pins.tms ? ST_UPDIR : ST_PAUIR;
      ST_PAUIR: st_d = pins.tms ? ST_EX2IR : ST_PAUIR;
      ST_EX2IR: st_d = pins.tms ? ST_UPDIR : ST_SHIR;
      ST_UPDIR: st_d = pins.tms ? ST_SELDR : ST_IDLE;
      default:  st_d = ST_RESET;
    endcase
  end

  // step state on test clock rising edge
  always_ff @(posedge clk)
  begin
    if (trst_act)
      st_q <= ST_RESET;
    else if (tck_rise)
      st_q <= st_d;
  end

  // ==========================================
  // instruction and data paths
  logic [IR_W-1:0]  ir_sh_q;
  logic [IR_W-1:0]  ir_q;
  logic [ID_W-1:0]  id_sh_q;
  logic [BSR_W-1:0] bs_sh_q;
  logic             byp_q;

  always_ff @(posedge clk)
  begin
    if (trst_act)
      ir_q <= IR_RESET_VAL;
    else if (tck_rise && st_q == ST_RESET)
      ir_q <= IR_RESET_VAL;
    else if (tck_rise && st_q == ST_UPDIR)
      ir_q <= ir_sh_q;
  end

  // capture serial input on rising edge
  always_ff @(posedge clk)
  begin
    if (trst_act)
    begin
      ir_sh_q <= IR_CAPTURE;
      id_sh_q <= ID_VALUE;
      bs_sh_q <= '0;
      byp_q   <= 1'b0;
    end
    else if (tck_rise)
    begin
      if (st_q == ST_CAPIR)
        ir_sh_q <= IR_CAPTURE;
      else if (st_q == ST_SHIR)
        ir_sh_q <= {pins.tdi, ir_sh_q[IR_W-1:1]};
      if (st_q == ST_CAPDR)
      begin
        id_sh_q <= ID_VALUE;
        byp_q   <= 1'b0;
      end
      else if (st_q == ST_SHDR)
      begin
        if (ir_q == IR_IDCODE)
          id_sh_q <= {pins.tdi, id_sh_q[ID_W-1:1]};
        else if (ir_q == IR_EXTEST)
          bs_sh_q <= {pins.tdi, bs_sh_q[BSR_W-1:1]};
        else
          byp_q <= pins.tdi;
      end
    end
  end

  // selected serial bit
  logic dr_bit;
  always_comb
  begin
    if (ir_q == IR_IDCODE)
      dr_bit = id_sh_q[0];
    else if (ir_q == IR_EXTEST)
      dr_bit = bs_sh_q[0];
    else
      dr_bit = byp_q;
  end

  // output changes on falling edge, enabled in shift states
  always_ff @(posedge clk)
  begin
    if (trst_act)
    begin
      test_serial_out_pin <= 1'b0;
      test_serial_out_oe  <= 1'b0;
    end
    else if (tck_fall)
    begin
      test_serial_out_pin <= (st_q == ST_SHIR) ? ir_sh_q[0] : dr_bit;
      test_serial_out_oe  <= (st_q == ST_SHIR) || (st_q == ST_SHDR);
    end
  end

  // ==========================================
  // device-wide controls
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      core_reset       <= 1'b1;
      test_mode_active <= 1'b0;
      io_pins_hiz      <= 1'b0;
    end
    else
    begin
      core_reset       <= ~crst_sy_q[1];
      // test reset low means normal operation
      test_mode_active <= rst_sy_q[1] && ir_q == IR_EXTEST;
      // both low puts io in high impedance
      io_pins_hiz      <= ~ioe_sy_q[1] & ~rst_sy_q[1];
    end
  end

  // ==========================================
  // checks
  // reset forces state
  a_trst_state: assert property (@(posedge clk) disable iff (srst)
    !rst_sy_q[1] |=> st_q == ST_RESET)
    else $error("test reset did not reset controller");
  a_trst_idcode: assert property (@(posedge clk) disable iff (srst)
    !rst_sy_q[1] |=> ir_q == IR_IDCODE)
    else $error("id code not selected after reset");
  a_state_hold: assert property (@(posedge clk) disable iff (srst)
    (!tck_rise && rst_sy_q[1]) |=> $stable(st_q))
    else $error("state changed without test clock edge");
  a_ir_shift: assert property (@(posedge clk) disable iff (srst)
    (tck_rise && st_q == ST_SHIR && rst_sy_q[1]) |=> ir_sh_q[IR_W-1] == $past(pins.tdi))
    else $error("instruction shift lost input bit");
  a_tdo_fall: assert property (@(posedge clk) disable iff (srst)
    (!tck_fall && rst_sy_q[1]) |=> $stable(test_serial_out_pin))
    else $error("serial output moved off falling edge");
  sequence s_both_low;
    !ioe_sy_q[1] && !rst_sy_q[1];
  endsequence
  a_io_hiz: assert property (@(posedge clk) disable iff (srst)
    s_both_low |=> io_pins_hiz)
    else $error("io not high impedance");
  a_normal_op: assert property (@(posedge clk) disable iff (srst)
    !rst_sy_q[1] ##1 !rst_sy_q[1] |=> !test_mode_active)
    else $error("test mode active under test reset");
  a_core_rst: assert property (@(posedge clk) disable iff (srst)
    !crst_sy_q[1] |=> core_reset)
    else $error("chip reset not applied");
  a_ir_update: assert property (@(posedge clk) disable iff (srst)
    (tck_rise && st_q == ST_UPDIR && rst_sy_q[1]) |=> ir_q == $past(ir_sh_q))
    else $error("instruction not updated");

endmodule : tag_test_port

// [bench/tag_scan_ctl.sv]
// boundary-scan controller model driving the test pins
`timescale 1ns/1ps
module tag_scan_ctl
  import tag_pkg::*;
(
  // system
  input  wire logic clk,
  // test pins
  output logic      test_port_reset_n,
  output tag_pins_t pins,
  input  wire logic test_serial_out_pin,
  input  wire logic test_serial_out_oe
);
  logic tdo_s;
  logic oe_s;

  // ==========================================
  // pin driving
  // idle hold low
  // test reset low, clock still, released lines at pull-up level
  initial
  begin
    test_port_reset_n = 1'b0;
    pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    tdo_s = 1'b0;
    oe_s = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic set_rst(input logic v);
    wait_clk(1);
    test_port_reset_n = v;
  endtask : set_rst

  // one test clock period of 8 clk (200 ns), output looked at late in the low phase
  task automatic step(input logic tms, input logic tdi);
    pins.tms = tms;
    pins.tdi = tdi;
    wait_clk(1);
    pins.tck = 1'b1;
    wait_clk(4);
    pins.tck = 1'b0;
    wait_clk(3);
    // released output has no pull, so show it as the inverse of its last value
    tdo_s = test_serial_out_oe ? test_serial_out_pin : ~test_serial_out_pin;
    oe_s = test_serial_out_oe;
  endtask : step

  // full scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic all_oe);
    dout = '0;
    all_oe = 1'b1;
    step(1'b1, 1'($urandom));
    if (ir)
      step(1'b1, 1'($urandom));
    step(1'b0, 1'($urandom));
    step(1'b0, 1'($urandom));
    for (int i = 0; i < n; i++)
    begin
      dout[i] = tdo_s;
      all_oe = all_oe & oe_s;
      step(i == n - 1, din[i]);
    end
    step(1'b1, 1'($urandom));
    step(1'b0, 1'($urandom));
  endtask : scan
endmodule : tag_scan_ctl

// [bench/tag_test_port_bench.sv]
// self-checking bench for the test access port block
`timescale 1ns/1ps
module tag_test_port_bench;
  import tag_pkg::*;
  logic        clk, srst, chip_reset_n, digital_io_enable_pin, trst_n;
  logic        tdo, oe, core_reset, test_mode_active, io_pins_hiz, all_oe;
  tag_pins_t   pins;
  logic [31:0] dout;
  logic [7:0]  din;
  logic [2:0]  v;
  int          err_count, samples_checked;

  // ==========================================
  // clock and instances
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  tag_test_port dut_u (.clk(clk), .srst(srst), .chip_reset_n(chip_reset_n),
    .digital_io_enable_pin(digital_io_enable_pin), .test_port_reset_n(trst_n),
    .test_clock_pin(pins.tck), .test_mode_select_pin(pins.tms), .test_serial_in_pin(pins.tdi),
    .test_serial_out_pin(tdo), .test_serial_out_oe(oe), .core_reset(core_reset),
    .test_mode_active(test_mode_active), .io_pins_hiz(io_pins_hiz));

  tag_scan_ctl ctl_u (.clk(clk), .test_port_reset_n(trst_n), .pins(pins),
    .test_serial_out_pin(tdo), .test_serial_out_oe(oe));

  // ==========================================
  // checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic hiz_exp(input logic en, input logic rn);
    return !en && !rn;
  endfunction : hiz_exp

  function automatic logic [31:0] byp_exp(input logic [7:0] d);
    return {24'h0, d[6:0], 1'b0};
  endfunction : byp_exp

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ==========================================
  // watchdog
  initial
  begin
    #1000000;
    err_count++;
    $display("BAD t=%0t run did not finish", $time);
    end_sim();
  end

  // ==========================================
  // tests
  initial
  begin
    srst = 1'b1;
    chip_reset_n = 1'b0;
    digital_io_enable_pin = 1'b1;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(36779));
    ctl_u.wait_clk(12);
    srst = 1'b0;
    ctl_u.wait_clk(6);
    chk({31'h0, core_reset}, 32'h1);
    chip_reset_n = 1'b1;
    ctl_u.wait_clk(6);
    chk({31'h0, core_reset}, 32'h0);
    $display("test core reset done");
    // four corners first, then random enable, test reset and chip reset
    for (int k = 0; k < 12; k++)
    begin
      v = (k < 4) ? {1'b1, k[1:0]} : 3'($urandom);
      digital_io_enable_pin = v[0];
      chip_reset_n = v[2];
      ctl_u.set_rst(v[1]);
      ctl_u.wait_clk(6);
      chk({31'h0, io_pins_hiz}, {31'h0, hiz_exp(v[0], v[1])});
      chk({31'h0, core_reset}, {31'h0, !v[2]});
    end
    // io enable back high for normal operation
    digital_io_enable_pin = 1'b1;
    chip_reset_n = 1'b1;
    ctl_u.set_rst(1'b1);
    ctl_u.wait_clk(6);
    $display("test pin enable done");
    ctl_u.step(1'b0, 1'b1);
    ctl_u.scan(1'b0, 32, $urandom, dout, all_oe);
    chk(dout, ID_VALUE);
    chk({31'h0, all_oe}, 32'h1);
    chk({31'h0, oe}, 32'h0);
    $display("test id read done");
    for (int r = 0; r < 4; r++)
    begin
      din = 8'($urandom);
      ctl_u.scan(1'b1, 2, {30'h0, IR_BYPASS}, dout, all_oe);
      chk(dout, {30'h0, IR_CAPTURE});
      ctl_u.scan(1'b0, 8, {24'h0, din}, dout, all_oe);
      chk(dout, byp_exp(din));
    end
    $display("test bypass done");
    ctl_u.scan(1'b1, 2, {30'h0, IR_EXTEST}, dout, all_oe);
    ctl_u.wait_clk(6);
    chk({31'h0, test_mode_active}, 32'h1);
    ctl_u.step(1'b1, 1'b1);
    ctl_u.step(1'b0, 1'b1);
    ctl_u.step(1'b0, 1'b1);
    ctl_u.step(1'b0, 1'b0);
    ctl_u.set_rst(1'b0);
    ctl_u.wait_clk(6);
    chk({31'h0, test_mode_active}, 32'h0);
    chk({31'h0, oe}, 32'h0);
    chk({31'h0, io_pins_hiz}, 32'h0);
    ctl_u.set_rst(1'b1);
    ctl_u.wait_clk(3);
    ctl_u.step(1'b0, 1'b1);
    ctl_u.scan(1'b0, 32, $urandom, dout, all_oe);
    chk(dout, ID_VALUE);
    $display("test reset mid scan done");
    end_sim();
  end
endmodule : tag_test_port_bench
